// ===== design/hcr_router.sv
/*
  Host command router: frames host commands, executes local ones, forwards
  the rest to the temperature controller, relays its replies, drives the
  heater DAC port, valves and cooler, and offers a small register port.
  Assumes all inputs synchronous to ref_clk and a program memory outside.
*/
// The address map and the strobed register port were chosen for this implementation.
// Functional notes
// - The host link runs 9600 baud, 1 start bit, even parity, 1 stop bit, three wires.
// - The controller link uses the same character format, 9600 baud by default.
// - A local command changes the controller link rate; the host rate stays fixed.
// - Codes 0x02, 0x03, 0x04 and 0x05 delimit messages and read requests.
// - Acceptance is answered with 0x06 and rejection with 0x15.
// - Each received host command is judged as local or for the controller.
// - A command that is not local goes unchanged to the controller link.
// - Replies from the controller are relayed back to the host.
// - With the heat exchanger fitted, all four valves close while heater power is off.
// - The gas cooler enable follows the probe heater being on.
// - The nitrogen heater value drives eight parallel outputs to the DAC.
// - Overheat, gas flow, nitrogen level and heater power status are sampled.
// - A firmware image received from the host is written to 64 K program memory.
// - A 256-byte store keeps identification data, written by host commands.
// - A command not allowed by the fitted options is answered with a negative code.
`timescale 1ns/1ns
module hcr_router #(
  parameter int unsigned BIT_CYC = hcr_pkg::BIT_CYC,
  parameter int unsigned BUF_DEPTH = hcr_pkg::BUF_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic host_rxd,
  output logic host_txd,
  input wire logic ctrl_rxd,
  output logic ctrl_txd,
  output logic [7:0] heater_dac_output_port,
  output logic [3:0] gas_valve,
  output logic cooler_en,
  output logic heater_en,
  output logic n2_heater_en,
  input wire logic overheat_in,
  input wire logic flow_in,
  input wire logic n2_level_in,
  input wire logic heater_pwr_in,
  input wire logic opt_evap_in,
  input wire logic opt_exch_in,
  output logic prog_we,
  output logic [15:0] prog_addr,
  output logic [7:0] prog_data
);
  localparam int unsigned IW = $clog2(BUF_DEPTH);
  localparam int unsigned DW = hcr_pkg::DIV_W;
  localparam int unsigned EW = hcr_pkg::IRQ_W;
  typedef struct packed {
    hcr_pkg::hcr_state_t st;
    logic [BUF_DEPTH-1:0][7:0] fbuf;
    logic [IW-1:0] cnt;
    logic [IW-1:0] idx;
    logic [IW-1:0] stx_pos;
    logic [IW-1:0] etx_pos;
    logic enq;
    logic dl_go;
    logic [7:0] reply;
    logic [7:0] relay;
    logic relay_v;
    logic ovh;
    logic flow;
    logic lvl;
    logic hpwr;
    logic evap;
    logic exch;
    logic heat_on;
    logic n2_on;
    logic [3:0] valve;
    logic [7:0] dac;
    logic [2:0] speed;
    logic [7:0] nv_addr;
    logic [15:0] dl_addr;
    logic [EW-1:0] ev;
    logic [EW-1:0] mask;
    logic [31:0] rdata;
    logic irq;
    logic [3:0] valve_o;
    logic cool_o;
    logic [7:0] dac_o;
    logic heat_o;
    logic n2_o;
    logic pwe;
    logic [15:0] paddr;
    logic [7:0] pdata;
  } hcr_regs_t;
  hcr_regs_t q, d;
  logic [7:0] nv_mem [256];
  logic nv_we;
  logic [7:0] nv_wa, nv_wd;
  logic [DW-1:0] ctrl_div;
  logic [15:0] cmd_w;
  logic htx_start, htx_ready, hrx_valid, hrx_err;
  logic ctx_start, ctx_ready, crx_valid, crx_err;
  logic [7:0] htx_data, hrx_data, ctx_data, crx_data;

  function automatic logic [4:0] hexv(input logic [7:0] c);
    hexv = 5'h00;
    if (c >= hcr_pkg::ASC_0 && c <= hcr_pkg::ASC_9) begin
      hexv = {1'b1, 4'(c - hcr_pkg::ASC_0)};
    end else if (c >= hcr_pkg::ASC_A && c <= hcr_pkg::ASC_F) begin
      hexv = {1'b1, 4'(c - hcr_pkg::ASC_A) + hcr_pkg::HEX_TEN};
    end
  endfunction

  // Only the controller side rate moves; the host port always runs BIT_CYC.
  always_comb begin
    case (q.speed)
      hcr_pkg::SPD_19200: ctrl_div = DW'(BIT_CYC) >> 1;
      hcr_pkg::SPD_4800: ctrl_div = DW'(BIT_CYC) << 1;
      hcr_pkg::SPD_2400: ctrl_div = DW'(BIT_CYC) << 2;
      hcr_pkg::SPD_1200: ctrl_div = DW'(BIT_CYC) << 3;
      default: ctrl_div = DW'(BIT_CYC);
    endcase
  end

  hcr_uart u_host (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .div(DW'(BIT_CYC)),
    .rx_in(host_rxd), .tx_out(host_txd), .tx_data(htx_data), .tx_start(htx_start),
    .tx_ready(htx_ready), .rx_data(hrx_data), .rx_valid(hrx_valid), .rx_err(hrx_err));
  hcr_uart u_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .div(ctrl_div),
    .rx_in(ctrl_rxd), .tx_out(ctrl_txd), .tx_data(ctx_data), .tx_start(ctx_start),
    .tx_ready(ctx_ready), .rx_data(crx_data), .rx_valid(crx_valid), .rx_err(crx_err));

  // A write names its command after STX, a read just before ENQ.
  assign cmd_w = q.enq ? {q.fbuf[q.cnt - IW'(3)], q.fbuf[q.cnt - IW'(2)]}
                       : {q.fbuf[q.stx_pos + IW'(1)], q.fbuf[q.stx_pos + IW'(2)]};

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] c1, c2, c3, c4, c5;
    logic [4:0] h1, h2, h3, h4;
    logic [EW-1:0] set, clr;
    logic loc, ok;
    c1 = q.fbuf[q.etx_pos - IW'(1)];
    c2 = q.fbuf[q.etx_pos - IW'(2)];
    c3 = q.fbuf[q.etx_pos - IW'(3)];
    c4 = q.fbuf[q.etx_pos - IW'(4)];
    c5 = q.fbuf[q.etx_pos - IW'(5)];
    h1 = hexv(c1);
    h2 = hexv(c2);
    h3 = hexv(c3);
    h4 = hexv(c4);
    set = '0;
    clr = '0;
    loc = 1'b1;
    ok = 1'b0;
    d = q;
    nv_we = 1'b0;
    nv_wa = q.nv_addr;
    nv_wd = reg_wdata[7:0];
    htx_start = 1'b0;
    htx_data = q.relay;
    ctx_start = 1'b0;
    ctx_data = q.fbuf[q.idx];
    d.pwe = 1'b0;
    d.rdata = '0;
    d.ovh = overheat_in;
    d.flow = flow_in;
    d.lvl = n2_level_in;
    d.hpwr = heater_pwr_in;
    d.evap = opt_evap_in;
    d.exch = opt_exch_in;
    set[hcr_pkg::EV_OVERHEAT] = overheat_in && !q.ovh;
    set[hcr_pkg::EV_FLOW_LOST] = q.flow && !flow_in;
    set[hcr_pkg::EV_LEVEL_LOW] = q.lvl && !n2_level_in && q.evap;
    set[hcr_pkg::EV_LINK_ERR] = hrx_err || crx_err;
    if (hrx_valid) begin
      unique case (q.st)
        hcr_pkg::S_IDLE: if (hrx_data == hcr_pkg::CH_EOT) begin
          d.fbuf[0] = hrx_data;
          d.cnt = IW'(1);
          d.st = hcr_pkg::S_COLLECT;
        end
        hcr_pkg::S_COLLECT: begin
          d.fbuf[q.cnt] = hrx_data;
          d.cnt = q.cnt + IW'(1);
          if (hrx_data == hcr_pkg::CH_EOT) begin
            d.fbuf[0] = hrx_data;
            d.cnt = IW'(1);
          end else if (hrx_data == hcr_pkg::CH_STX) begin
            d.stx_pos = q.cnt;
          end else if (hrx_data == hcr_pkg::CH_ENQ) begin
            d.enq = 1'b1;
            d.st = hcr_pkg::S_DECIDE;
          end else if (hrx_data == hcr_pkg::CH_ETX) begin
            d.enq = 1'b0;
            d.etx_pos = q.cnt;
            d.st = hcr_pkg::S_BCC;
          end else if (q.cnt == IW'(BUF_DEPTH - 1)) begin
            d.reply = hcr_pkg::CH_NAK;
            d.dl_go = 1'b0;
            d.st = hcr_pkg::S_REPLY;
            set[hcr_pkg::EV_NAK] = 1'b1;
          end
        end
        hcr_pkg::S_BCC: begin
          d.fbuf[q.cnt] = hrx_data;
          d.cnt = q.cnt + IW'(1);
          d.st = hcr_pkg::S_DECIDE;
        end
        hcr_pkg::S_DNLD: begin
          d.pwe = 1'b1;
          d.paddr = q.dl_addr;
          d.pdata = hrx_data;
          d.dl_addr = q.dl_addr + 16'h0001;
          if (q.dl_addr == hcr_pkg::PROG_LAST) begin
            d.st = hcr_pkg::S_IDLE;
            set[hcr_pkg::EV_DL_DONE] = 1'b1;
          end
        end
        default: set[hcr_pkg::EV_OVERRUN] = 1'b1;
      endcase
    end
    // Local reads by enquiry are not served here; software reads the registers.
    if (q.st == hcr_pkg::S_DECIDE) begin
      d.dl_go = 1'b0;
      unique case (cmd_w)
        hcr_pkg::CMD_AIR: if (!q.enq && (c1[7:1] == hcr_pkg::ASC_0[7:1])
            && (c2[7:1] == hcr_pkg::ASC_0[7:1]) && (c3[7:1] == hcr_pkg::ASC_0[7:1])
            && (c4[7:1] == hcr_pkg::ASC_0[7:1])) begin
          ok = 1'b1;
          d.valve = {c4[0], c3[0], c2[0], c1[0]};
        end
        hcr_pkg::CMD_LINK_SPEED: if (!q.enq) begin
          ok = 1'b1;
          if (c5 == hcr_pkg::ASC_1 && c4 == hcr_pkg::ASC_9) d.speed = hcr_pkg::SPD_19200;
          else if (c4 == hcr_pkg::ASC_9) d.speed = hcr_pkg::SPD_9600;
          else if (c4 == hcr_pkg::ASC_4) d.speed = hcr_pkg::SPD_4800;
          else if (c4 == hcr_pkg::ASC_2) d.speed = hcr_pkg::SPD_2400;
          else if (c4 == hcr_pkg::ASC_1) d.speed = hcr_pkg::SPD_1200;
          else ok = 1'b0;
        end
        hcr_pkg::CMD_HEAT: if (!q.enq && c1[7:1] == hcr_pkg::ASC_0[7:1]) begin
          ok = 1'b1;
          d.heat_on = c1[0];
        end
        hcr_pkg::CMD_N2_LEVEL: if (!q.enq && q.evap && h1[4] && h2[4]) begin
          ok = 1'b1;
          d.dac = {h2[3:0], h1[3:0]};
        end
        hcr_pkg::CMD_N2_PWR: if (!q.enq && q.evap && c1[7:1] == hcr_pkg::ASC_0[7:1]) begin
          ok = 1'b1;
          d.n2_on = c1[0];
        end
        hcr_pkg::CMD_NV_WRITE: if (!q.enq && h1[4] && h2[4] && h3[4] && h4[4]) begin
          ok = 1'b1;
          nv_we = 1'b1;
          nv_wa = {h4[3:0], h3[3:0]};
          nv_wd = {h2[3:0], h1[3:0]};
        end
        hcr_pkg::CMD_DOWNLOAD: if (!q.enq) begin
          ok = 1'b1;
          d.dl_go = 1'b1;
        end
        default: loc = 1'b0;
      endcase
      if (loc) begin
        d.reply = ok ? hcr_pkg::CH_ACK : hcr_pkg::CH_NAK;
        set[hcr_pkg::EV_NAK] = !ok;
        d.st = hcr_pkg::S_REPLY;
      end else begin
        d.idx = '0;
        d.st = hcr_pkg::S_FWD;
      end
    end
    if (q.st == hcr_pkg::S_FWD && ctx_ready) begin
      ctx_start = 1'b1;
      d.idx = q.idx + IW'(1);
      if (q.idx == q.cnt - IW'(1)) d.st = hcr_pkg::S_IDLE;
    end
    // A reply outranks relayed traffic; one relay byte is held meanwhile.
    if (htx_ready) begin
      if (q.st == hcr_pkg::S_REPLY) begin
        htx_start = 1'b1;
        htx_data = q.reply;
        d.dl_addr = '0;
        d.st = q.dl_go ? hcr_pkg::S_DNLD : hcr_pkg::S_IDLE;
      end else if (q.relay_v) begin
        htx_start = 1'b1;
        d.relay_v = 1'b0;
      end
    end
    if (crx_valid) begin
      if (d.relay_v) set[hcr_pkg::EV_OVERRUN] = 1'b1;
      else begin
        d.relay = crx_data;
        d.relay_v = 1'b1;
      end
    end
    //////////////////////////////////////////////////////////////////////////
    if (reg_wr) begin
      unique case (reg_addr)
        hcr_pkg::REG_IRQ: clr = reg_wdata[EW-1:0];
        hcr_pkg::REG_MASK: d.mask = reg_wdata[EW-1:0];
        hcr_pkg::REG_CTRL: begin
          d.heat_on = reg_wdata[hcr_pkg::CTRL_HEAT];
          d.n2_on = reg_wdata[hcr_pkg::CTRL_N2];
          d.valve = reg_wdata[hcr_pkg::CTRL_VALVE +: 4];
          if (reg_wdata[hcr_pkg::CTRL_ABORT] && q.st == hcr_pkg::S_DNLD) d.st = hcr_pkg::S_IDLE;
        end
        hcr_pkg::REG_DAC: d.dac = reg_wdata[7:0];
        hcr_pkg::REG_SPEED: d.speed = reg_wdata[2:0];
        hcr_pkg::REG_NV_ADDR: d.nv_addr = reg_wdata[7:0];
        hcr_pkg::REG_NV_DATA: begin
          nv_we = 1'b1;
          nv_wa = q.nv_addr;
          nv_wd = reg_wdata[7:0];
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        hcr_pkg::REG_STATUS: d.rdata = {q.st, 19'h0_0000, q.exch, q.evap, q.hpwr, q.lvl,
                                        q.flow, q.ovh};
        hcr_pkg::REG_IRQ: d.rdata = 32'(q.ev);
        hcr_pkg::REG_MASK: d.rdata = 32'(q.mask);
        hcr_pkg::REG_CTRL: d.rdata = {24'h00_0000, q.valve, 2'b00, q.n2_on, q.heat_on};
        hcr_pkg::REG_DAC: d.rdata = 32'(q.dac);
        hcr_pkg::REG_SPEED: d.rdata = 32'(q.speed);
        hcr_pkg::REG_NV_ADDR: d.rdata = 32'(q.nv_addr);
        hcr_pkg::REG_NV_DATA: d.rdata = 32'(nv_mem[q.nv_addr]);
        hcr_pkg::REG_PROG_ADDR: d.rdata = 32'(q.dl_addr);
        default: d.rdata = '0;
      endcase
    end
    // Set wins over a same-cycle clear so no event is lost.
    d.ev = (q.ev & ~clr) | set;
    d.irq = |(q.ev & q.mask);
    d.valve_o = (q.exch && !(q.heat_on && q.hpwr)) ? '0 : q.valve;
    d.cool_o = q.heat_on && q.hpwr;
    d.dac_o = q.dac;
    d.heat_o = q.heat_on && !q.ovh && q.flow;
    d.n2_o = q.n2_on && q.evap;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= hcr_pkg::S_IDLE;
      q.speed <= hcr_pkg::SPD_9600;
      q.valve <= hcr_pkg::VALVE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // The identification store has no reset: it models nonvolatile contents.
  always_ff @(posedge ref_clk) begin
    if (ce && nv_we) nv_mem[nv_wa] <= nv_wd;
  end

  assign reg_rdata = q.rdata;
  assign irq = q.irq;
  assign heater_dac_output_port = q.dac_o;
  assign gas_valve = q.valve_o;
  assign cooler_en = q.cool_o;
  assign heater_en = q.heat_o;
  assign n2_heater_en = q.n2_o;
  assign prog_we = q.pwe;
  assign prog_addr = q.paddr;
  assign prog_data = q.pdata;

  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_frame_opens: assert property (ce && q.st == hcr_pkg::S_IDLE && hrx_valid
    && hrx_data == hcr_pkg::CH_EOT |=> q.st == hcr_pkg::S_COLLECT && q.cnt == IW'(1))
    else $error("frame not opened by EOT");
  a_reply_code: assert property (ce && htx_start && q.st == hcr_pkg::S_REPLY
    |-> htx_data == hcr_pkg::CH_ACK || htx_data == hcr_pkg::CH_NAK)
    else $error("bad reply code");
  a_route_split: assert property (ce && q.st == hcr_pkg::S_DECIDE
    |=> q.st == hcr_pkg::S_REPLY || q.st == hcr_pkg::S_FWD)
    else $error("no routing decision");
  a_fwd_unchanged: assert property (ce && ctx_start
    |-> q.st == hcr_pkg::S_FWD && ctx_data == q.fbuf[q.idx] ##1 q.idx == $past(q.idx) + IW'(1))
    else $error("forwarded byte differs");
  a_relay_taken: assert property (ce && crx_valid && !q.relay_v
    |=> q.relay_v && q.relay == $past(crx_data))
    else $error("controller byte not held");
  a_valves_closed: assert property (ce && q.exch && !(q.heat_on && q.hpwr)
    |=> gas_valve == 4'h0)
    else $error("valves open without heater");
  a_cooler_follow: assert property (ce
    |=> cooler_en == ($past(q.heat_on) && $past(q.hpwr)))
    else $error("cooler enable wrong");
  a_dac_port: assert property (ce |=> heater_dac_output_port == $past(q.dac))
    else $error("dac port stale");
  a_speed_default: assert property (q.speed == hcr_pkg::SPD_9600
    |-> ctrl_div == DW'(BIT_CYC))
    else $error("controller rate wrong");
  a_prog_write: assert property (ce && q.st == hcr_pkg::S_DNLD && hrx_valid
    |=> prog_we && prog_data == $past(hrx_data) && prog_addr == $past(q.dl_addr))
    else $error("download byte not written");
  a_option_nack: assert property (ce && q.st == hcr_pkg::S_DECIDE && !q.evap
    && (cmd_w == hcr_pkg::CMD_N2_LEVEL || cmd_w == hcr_pkg::CMD_N2_PWR)
    |=> q.st == hcr_pkg::S_REPLY && q.reply == hcr_pkg::CH_NAK)
    else $error("option command not refused");
  a_buffer_holds: assert property (ce && q.st == hcr_pkg::S_COLLECT && hrx_valid
    && hrx_data != hcr_pkg::CH_ETX && hrx_data != hcr_pkg::CH_ENQ
    && q.cnt != IW'(BUF_DEPTH - 1) |=> q.st == hcr_pkg::S_COLLECT)
    else $error("routed before frame end");
  c_forward: cover property (q.st == hcr_pkg::S_FWD ##1 q.st == hcr_pkg::S_IDLE);
  c_ack_sent: cover property (htx_start && htx_data == hcr_pkg::CH_ACK);
  c_download: cover property (q.st == hcr_pkg::S_DNLD && hrx_valid);
  c_relay: cover property (htx_start && q.relay_v && q.st != hcr_pkg::S_REPLY);
endmodule

// ===== design/hcr_pkg.sv
/*
  Shared constants and types of the host command router: character codes,
  command names, register offsets, field positions, reset values, states.
  Assumes a single 100 MHz system clock.
*/
package hcr_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_HZ = 9600;
  // Bit time in clock cycles; integer division rounds down.
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD_HZ;
  localparam int unsigned BUF_DEPTH = 32;
  localparam int unsigned DIV_W = 17;
  localparam int unsigned IRQ_W = 7;
  //////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_EOT = 8'h04;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] ASC_0 = 8'h30;
  localparam logic [7:0] ASC_1 = 8'h31;
  localparam logic [7:0] ASC_2 = 8'h32;
  localparam logic [7:0] ASC_4 = 8'h34;
  localparam logic [7:0] ASC_9 = 8'h39;
  localparam logic [7:0] ASC_A = 8'h41;
  localparam logic [7:0] ASC_F = 8'h46;
  localparam logic [3:0] HEX_TEN = 4'ha;
  //////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] CMD_AIR = 16'h4146;
  localparam logic [15:0] CMD_LINK_SPEED = 16'h434f;
  localparam logic [15:0] CMD_HEAT = 16'h4850;
  localparam logic [15:0] CMD_N2_LEVEL = 16'h4e48;
  localparam logic [15:0] CMD_N2_PWR = 16'h4e50;
  localparam logic [15:0] CMD_NV_WRITE = 16'h5742;
  localparam logic [15:0] CMD_DOWNLOAD = 16'h444c;
  localparam logic [2:0] SPD_19200 = 3'h0;
  localparam logic [2:0] SPD_9600 = 3'h1;
  localparam logic [2:0] SPD_4800 = 3'h2;
  localparam logic [2:0] SPD_2400 = 3'h3;
  localparam logic [2:0] SPD_1200 = 3'h4;
  //////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam logic [7:0] REG_DAC = 8'h10;
  localparam logic [7:0] REG_SPEED = 8'h14;
  localparam logic [7:0] REG_NV_ADDR = 8'h18;
  localparam logic [7:0] REG_NV_DATA = 8'h1c;
  localparam logic [7:0] REG_PROG_ADDR = 8'h20;
  localparam int unsigned CTRL_HEAT = 0;
  localparam int unsigned CTRL_N2 = 1;
  localparam int unsigned CTRL_ABORT = 2;
  localparam int unsigned CTRL_VALVE = 4;
  localparam int unsigned EV_OVERHEAT = 0;
  localparam int unsigned EV_FLOW_LOST = 1;
  localparam int unsigned EV_LEVEL_LOW = 2;
  localparam int unsigned EV_LINK_ERR = 3;
  localparam int unsigned EV_OVERRUN = 4;
  localparam int unsigned EV_NAK = 5;
  localparam int unsigned EV_DL_DONE = 6;
  localparam logic [3:0] VALVE_RST = 4'h0;
  localparam logic [15:0] PROG_LAST = 16'hffff;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_COLLECT = 7'h02, S_BCC = 7'h04, S_DECIDE = 7'h08,
    S_FWD = 7'h10, S_REPLY = 7'h20, S_DNLD = 7'h40
  } hcr_state_t;
endpackage

// ===== design/hcr_uart.sv
/*
  One serial port: 1 start bit, 8 data bits, even parity, 1 stop bit.
  Assumes rx_in synchronous to ref_clk and div giving clock cycles per bit.
*/
`timescale 1ns/1ns
module hcr_uart #(
  parameter int unsigned DIV_W = hcr_pkg::DIV_W
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [DIV_W-1:0] div,
  input wire logic rx_in,
  output logic tx_out,
  input wire logic [7:0] tx_data,
  input wire logic tx_start,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err
);
  typedef struct packed {
    logic [DIV_W-1:0] tcnt;
    logic [3:0] tbits;
    logic [9:0] tsh;
    logic tbusy;
    logic tout;
    logic [DIV_W-1:0] rcnt;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic rbusy;
    logic [7:0] rdat;
    logic rval;
    logic rerr;
  } hcr_uart_t;
  hcr_uart_t q, d;

  always_comb begin
    d = q;
    d.rval = 1'b0;
    d.rerr = 1'b0;
    // Even parity: the parity bit makes the count of ones even.
    if (!q.tbusy) begin
      if (tx_start) begin
        d.tbusy = 1'b1;
        d.tout = 1'b0;
        d.tsh = {1'b1, ^tx_data, tx_data};
        d.tbits = 4'ha;
        d.tcnt = div - DIV_W'(1);
      end
    end else if (q.tcnt != '0) begin
      d.tcnt = q.tcnt - DIV_W'(1);
    end else if (q.tbits == 4'h0) begin
      d.tbusy = 1'b0;
      d.tout = 1'b1;
    end else begin
      d.tout = q.tsh[0];
      d.tsh = {1'b1, q.tsh[9:1]};
      d.tbits = q.tbits - 4'h1;
      d.tcnt = div - DIV_W'(1);
    end
    //////////////////////////////////////////////////////////////////////////
    if (!q.rbusy) begin
      if (!rx_in) begin
        d.rbusy = 1'b1;
        d.rbit = 4'h0;
        d.rcnt = div >> 1;
      end
    end else if (q.rcnt != '0) begin
      d.rcnt = q.rcnt - DIV_W'(1);
    end else begin
      d.rcnt = div - DIV_W'(1);
      d.rbit = q.rbit + 4'h1;
      if (q.rbit == 4'h0) begin
        d.rbusy = !rx_in;
      end else if (q.rbit < 4'ha) begin
        d.rsh = {rx_in, q.rsh[8:1]};
      end else begin
        d.rbusy = 1'b0;
        d.rval = 1'b1;
        d.rdat = q.rsh[7:0];
        d.rerr = !rx_in || (q.rsh[8] != ^q.rsh[7:0]);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.tout <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign tx_out = q.tout;
  assign tx_ready = !q.tbusy;
  assign rx_data = q.rdat;
  assign rx_valid = q.rval;
  assign rx_err = q.rerr;

  a_start_bit_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ce && tx_start && tx_ready) |=> (!tx_out && !tx_ready))
    else $error("start bit not sent");
endmodule

// ===== dv/hcr_ctrl_model.sv
/* Controller model: counts each frame's bytes from EOT and answers ENQ with the count.
   Assumes BC clock cycles per bit; its line idles high. */
`timescale 1ns/1ns
module hcr_ctrl_model #(parameter int BC = 16) (
  input wire logic ref_clk,
  input wire logic rx,
  output logic tx = 1'h1
);
  logic [7:0] b;
  logic [7:0] n = 8'h00;
  initial forever begin
    @(negedge rx);
    repeat (BC * 3 / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = rx;
      repeat (BC) @(posedge ref_clk);
    end
    n = (b == 8'h04) ? 8'h01 : n + 8'h01;
    if (b == 8'h05) begin
      for (int i = 0; i < 11; i++) begin
        tx <= i == 0 ? 1'h0 : i < 9 ? n[i-1] : i == 9 ? ^n : 1'h1;
        repeat (BC) @(posedge ref_clk);
      end
    end
  end
endmodule

// ===== dv/tb_host_command_router.sv
/* Router bench: host frames and register accesses against expected values.
   Assumes 16 clock cycles per serial bit and the controller model. */
`timescale 1ns/1ns
module tb_host_command_router;
  logic ref_clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, host_rxd = 1'h1;
  logic flow_in = 1'h0, heater_pwr_in = 1'h0, opt_exch_in = 1'h0, ce = 1'h1;
  logic host_txd, ctrl_txd, ctrl_rxd, irq, cooler_en, heater_en, n2_heater_en;
  logic [7:0] reg_addr = '0, dac, b, prog_data;
  logic [15:0] prog_addr;
  logic [31:0] reg_wdata = '0, reg_rdata, v;
  logic [3:0] gas_valve;
  int errors = 0, checked = 0;
  hcr_router #(.BIT_CYC(16)) u_dut (.ref_clk, .rst_b, .ce, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq, .host_rxd, .host_txd, .ctrl_rxd, .ctrl_txd,
    .heater_dac_output_port(dac), .gas_valve, .cooler_en, .heater_en, .n2_heater_en,
    .overheat_in(1'h0), .flow_in, .n2_level_in(1'h0), .heater_pwr_in, .opt_evap_in(1'h0),
    .opt_exch_in, .prog_we(), .prog_addr, .prog_data);
  hcr_ctrl_model u_ctrl (.ref_clk(ref_clk), .rx(ctrl_txd), .tx(ctrl_rxd));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    errors += int'(seen !== exp);
    if (seen !== exp) $display("Error %s: expected %h seen %h", s, exp, seen);
  endtask
  task automatic test_done(input int t);
    errors += t;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge ref_clk);
    {reg_wr, reg_rd} <= 2'h0;
    @(posedge ref_clk);
    v = reg_rdata;
  endtask
  task automatic sendv(input logic [95:0] s, input int n);
    logic [10:0] f;
    for (int k = n - 1; k >= 0; k--) begin
      f = {1'h1, ^s[8*k+:8], s[8*k+:8], 1'h0};
      repeat (8) @(posedge ref_clk);
      for (int i = 0; i < 11; i++) begin
        host_rxd <= f[i];
        repeat (i == 10 ? 8 : 16) @(posedge ref_clk);
      end
    end
  endtask
  task automatic getb();
    for (int n = 0; host_txd === 1'h1; n++) begin
      if (n > 6000) test_done(1);
      @(posedge ref_clk);
    end
    repeat (24) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = host_txd;
      repeat (16) @(posedge ref_clk);
    end
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'h1;
    {flow_in, heater_pwr_in, opt_exch_in} <= 3'h7;
    acc(1'h1, hcr_pkg::REG_CTRL, 32'h0000_00f0);
    acc(1'h1, hcr_pkg::REG_MASK, 32'h0000_0020);
    chk("valves", gas_valve, 0);
    sendv({8'h04, "0000", 8'h02, "HP1", 8'h03, 8'h00}, 11);
    getb();
    chk("reply", b, 8'h06);
    chk("cooler", cooler_en, 1);
    chk("valves", gas_valve, 4'hf);
    chk("heater", heater_en, 1);
    $display("test 1 done");
    sendv({8'h04, "0000", 8'h02, "NH5A", 8'h03, 8'h00}, 12);
    getb();
    chk("reply", b, 8'h15);
    chk("irq", irq, 1);
    acc(1'h1, hcr_pkg::REG_IRQ, 32'h0000_0020);
    acc(1'h1, hcr_pkg::REG_DAC, 32'h0000_005a);
    acc(1'h0, hcr_pkg::REG_SPEED, 0);
    chk("speed", v, hcr_pkg::SPD_9600);
    chk("irq", irq, 0);
    chk("dac", dac, 8'h5a);
    ce <= 1'h0;
    acc(1'h1, hcr_pkg::REG_DAC, 32'h0000_0011);
    ce <= 1'h1;
    acc(1'h0, hcr_pkg::REG_DAC, 0);
    chk("frozen dac", v, 8'h5a);
    $display("test 2 done");
    sendv({8'h04, "0000XX", 8'h05}, 8);
    getb();
    chk("relay", b, 8'h08);
    $display("test 3 done");
    sendv({8'h04, "0000", 8'h02, "DL", 8'h03, 8'h00}, 10);
    getb();
    chk("reply", b, 8'h06);
    sendv(96'h5a, 1);
    repeat (8) @(posedge ref_clk);
    acc(1'h0, hcr_pkg::REG_PROG_ADDR, 0);
    chk("next addr", v, 1);
    chk("prog addr", prog_addr, 0);
    chk("prog data", prog_data, 8'h5a);
    acc(1'h1, hcr_pkg::REG_CTRL, 32'h0000_00f7);
    acc(1'h0, hcr_pkg::REG_STATUS, 0);
    chk("status", v, 32'h0200_002a);
    chk("n2 heater", n2_heater_en, 0);
    $display("test 4 done");
    test_done(0);
  end
endmodule
